// ==== core/ref_out_pkg.sv ====
// Purpose: constants and types for the reference clock output block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: source clocks arrive as edge ticks in the pclk domain
// Behaviour
// R01: generated clock drives the output pin and the modulator source port.
// R02: input clock taken from one of several sources by a writable select.
// R03: enabling starts the output cleanly, first period complete, no runt pulse.
// R04: clearing enable forces the output low at once.
// R05: three-bit divider gives undivided or divide by 2 up to 128.
// R06: duty field gives 25, 50 or 75 percent except when undivided.
// R07: upper duty bit resets to one, default duty 50 percent.
// R08: divider and duty writes accepted while enabled, applied to running output.
// R09: software should change divider and duty only while disabled.
// R10: output keeps running in sleep while its source keeps running.
// R11: divider code 000 undivided, each higher code doubles, 111 divides by 128.
// R12: duty code 00 zero, 01 25, 10 50, 11 75 percent high.
package ref_out_pkg;
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_SOURCE = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam int POS_DIV = 0;
	localparam int POS_DUTY = 3;
	localparam int POS_EN = 7;
	localparam int POS_SRC = 0;
	localparam logic [2:0] RESET_DIV = 3'h0;
	localparam logic [1:0] RESET_DUTY = 2'h2;
	localparam logic [1:0] DUTY_ZERO = 2'h0;
	localparam logic [2:0] DIV_NONE = 3'h0;
	localparam int SRC_W = 2;
	localparam int CNT_W = 8;

	typedef struct packed {
		logic enable;
		logic [1:0] duty;
		logic [2:0] div;
	} ctrl_type;
endpackage

// ==== core/ref_out_shaper.sv ====
// Purpose: divide and duty-shape the selected source ticks
// Assumes: tick marks each edge of the source clock, two ticks per base period
// Notes: while enabled, output changes only on ticks, so it starts on a period boundary
`timescale 1ns/1ps
module ref_out_shaper
	import ref_out_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire ctrl_type cfg,
	output logic ref_q,
	output logic [CNT_W-1:0] count_q
);
	logic [CNT_W-1:0] last;
	logic [CNT_W-1:0] quarter;
	logic [CNT_W-1:0] thresh;
	logic high;

	// period in ticks is 2 << div
	always_comb begin
		last = CNT_W'((9'h002 << cfg.div) - 9'h001); // R05 R11
		quarter = CNT_W'((9'h002 << cfg.div) >> 2);
		thresh = CNT_W'(quarter * cfg.duty); // R06 R12
		if (cfg.div == DIV_NONE) begin
			high = (count_q == '0); // R06
		end else begin
			high = (count_q < thresh);
		end
	end

	// count always restarts from zero while disabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (!cfg.enable) begin
			count_q <= '0; // R03
		end else if (tick) begin
			count_q <= (count_q >= last) ? '0 : count_q + 1'b1; // R08
		end
	end

	// no sleep gating here: runs whenever enabled and ticks arrive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_q <= 1'b0;
		end else if (!cfg.enable) begin
			ref_q <= 1'b0; // R04
		end else if (tick) begin
			ref_q <= high; // R03 R10
		end
	end

	property p_off;
		@(posedge clk) disable iff (!rst_n) !cfg.enable |=> !ref_q && count_q == '0;
	endproperty
	a_off: assert property (p_off) else $error("output not stopped on disable"); // R04

	property p_duty_zero;
		@(posedge clk) disable iff (!rst_n)
		(cfg.enable && tick && cfg.duty == DUTY_ZERO && cfg.div != DIV_NONE) |=> !ref_q;
	endproperty
	a_duty_zero: assert property (p_duty_zero) else $error("zero duty gave high"); // R12

	property p_wrap;
		@(posedge clk) disable iff (!rst_n)
		(cfg.enable && tick && count_q == last) |=> count_q == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("divider did not wrap"); // R05

	sequence s_enable_rise;
		cfg.enable && !$past(cfg.enable);
	endsequence
	property p_clean_start;
		@(posedge clk) disable iff (!rst_n) s_enable_rise |-> !ref_q && count_q == '0;
	endproperty
	a_clean_start: assert property (p_clean_start) else $error("start not at period"); // R03

	property p_half;
		@(posedge clk) disable iff (!rst_n)
		(cfg.enable && tick && cfg.duty == RESET_DUTY && cfg.div != DIV_NONE)
		|=> ref_q == ($past(count_q) < ($past(last) >> 1) + 1'b1);
	endproperty
	a_half: assert property (p_half) else $error("50 percent duty wrong"); // R06
endmodule

// ==== core/ref_out_top.sv ====
// Purpose: reference clock output generator with apb control
// Assumes: src_tick inputs are single-cycle pclk-domain edge ticks
// Notes: one wait state on every apb access
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ref_out_top
	import ref_out_pkg::*;
#(
	parameter int NSRC = 4
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NSRC-1:0] src_tick,
	output logic ref_clock_out_pin,
	output logic modulator_ref_clk
);
	ctrl_type ref_out_control_q;
	logic [SRC_W-1:0] ref_out_source_sel_q;
	logic tick_q;
	logic ref_q;
	logic [CNT_W-1:0] count;
	logic access;
	logic mapped;

	assign access = psel && penable && !pready;
	assign mapped = (paddr == ADDR_CONTROL) || (paddr == ADDR_SOURCE) || (paddr == ADDR_STATUS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			pslverr <= access && !mapped;
		end
	end

	// writes while enabled are taken; software is expected to avoid them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_out_control_q <= '{enable: 1'b0, duty: RESET_DUTY, div: RESET_DIV}; // R07
		end else if (access && pwrite && paddr == ADDR_CONTROL) begin
			ref_out_control_q.enable <= pwdata[POS_EN];
			ref_out_control_q.duty <= pwdata[POS_DUTY +: 2]; // R08 R09
			ref_out_control_q.div <= pwdata[POS_DIV +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_out_source_sel_q <= '0;
		end else if (access && pwrite && paddr == ADDR_SOURCE) begin
			ref_out_source_sel_q <= pwdata[POS_SRC +: SRC_W]; // R02
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (access && !pwrite) begin
			prdata <= '0;
			unique case (paddr)
				ADDR_CONTROL: begin
					prdata[POS_EN] <= ref_out_control_q.enable;
					prdata[POS_DUTY +: 2] <= ref_out_control_q.duty;
					prdata[POS_DIV +: 3] <= ref_out_control_q.div;
				end
				ADDR_SOURCE: prdata[POS_SRC +: SRC_W] <= ref_out_source_sel_q;
				ADDR_STATUS: prdata[CNT_W:0] <= {count, ref_q};
				default: prdata <= '0;
			endcase
		end
	end

	// out-of-range select gives no ticks, so the output holds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= (32'(ref_out_source_sel_q) < NSRC) && src_tick[ref_out_source_sel_q]; // R02
		end
	end

	ref_out_shaper u_shaper (
		.clk(pclk),
		.rst_n(presetn),
		.tick(tick_q),
		.cfg(ref_out_control_q),
		.ref_q(ref_q),
		.count_q(count)
	);

	// both consumers see the same flop
	assign ref_clock_out_pin = ref_q; // R01
	assign modulator_ref_clk = ref_q; // R01

	property p_one_wait;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready ##1 !pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready not one cycle"); // R08

	property p_write_ctrl;
		@(posedge pclk) disable iff (!presetn)
		(access && pwrite && paddr == ADDR_CONTROL)
		|=> ref_out_control_q.duty == $past(pwdata[POS_DUTY +: 2])
		&& ref_out_control_q.enable == $past(pwdata[POS_EN]);
	endproperty
	a_write_ctrl: assert property (p_write_ctrl) else $error("control write lost"); // R08

	property p_reset_duty;
		@(posedge pclk) $rose(presetn) |-> ref_out_control_q.duty == RESET_DUTY;
	endproperty
	a_reset_duty: assert property (p_reset_duty) else $error("duty reset not 50"); // R07

	property p_tick_sel;
		@(posedge pclk) disable iff (!presetn)
		(src_tick[0] && ref_out_source_sel_q == '0) |=> tick_q;
	endproperty
	a_tick_sel: assert property (p_tick_sel) else $error("selected tick missed"); // R02

	// writes land at the first access edge, the same edge that raises pready
	sequence s_ctrl_write;
		access && pwrite && paddr == ADDR_CONTROL;
	endsequence

	sequence s_ctrl_off;
		s_ctrl_write ##0 !pwdata[POS_EN];
	endsequence

	sequence s_ctrl_on;
		s_ctrl_write ##0 pwdata[POS_EN] && !ref_out_control_q.enable;
	endsequence

	sequence s_undiv_tick;
		ref_out_control_q.enable && tick_q && ref_out_control_q.div == DIV_NONE;
	endsequence

	property p_div_write;
		@(posedge pclk) disable iff (!presetn)
		s_ctrl_write |=> ref_out_control_q.div == $past(pwdata[POS_DIV +: 3]);
	endproperty
	a_div_write: assert property (p_div_write) else $error("divider write lost"); // R11

	property p_src_write;
		@(posedge pclk) disable iff (!presetn)
		(access && pwrite && paddr == ADDR_SOURCE)
		|=> ref_out_source_sel_q == $past(pwdata[POS_SRC +: SRC_W]);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source write lost"); // R02

	// two edges: control flop first, then the output flop
	property p_stop;
		@(posedge pclk) disable iff (!presetn)
		s_ctrl_off |=> ##1 !ref_clock_out_pin && count == '0;
	endproperty
	a_stop: assert property (p_stop) else $error("output not stopped"); // R04

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		s_ctrl_on |=> !ref_clock_out_pin && count == '0;
	endproperty
	a_start: assert property (p_start) else $error("start not at phase zero"); // R03

	// while enabled, level moves only on ticks, so no runt pulse can appear
	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(ref_out_control_q.enable && !tick_q) |=> $stable(ref_q);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved between ticks"); // R03

	property p_tick_any;
		@(posedge pclk) disable iff (!presetn)
		tick_q |-> $past(src_tick[ref_out_source_sel_q]);
	endproperty
	a_tick_any: assert property (p_tick_any) else $error("tick from wrong source"); // R02

	// no sleep gating: every tick while enabled must move the phase
	property p_run;
		@(posedge pclk) disable iff (!presetn)
		(ref_out_control_q.enable && tick_q) |=> $changed(count);
	endproperty
	a_run: assert property (p_run) else $error("phase counter stalled"); // R10

	property p_undiv_rise;
		@(posedge pclk) disable iff (!presetn)
		s_undiv_tick ##0 count == '0 |=> ref_clock_out_pin;
	endproperty
	a_undiv_rise: assert property (p_undiv_rise) else $error("undivided not high"); // R06

	property p_undiv_fall;
		@(posedge pclk) disable iff (!presetn)
		s_undiv_tick ##0 count != '0 |=> !ref_clock_out_pin;
	endproperty
	a_undiv_fall: assert property (p_undiv_fall) else $error("undivided not low"); // R06

	property p_read_ctrl;
		@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && paddr == ADDR_CONTROL)
		|=> prdata[POS_DUTY +: 2] == $past(ref_out_control_q.duty)
		&& prdata[POS_DIV +: 3] == $past(ref_out_control_q.div);
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong"); // R12

	property p_read_src;
		@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && paddr == ADDR_SOURCE)
		|=> prdata[POS_SRC +: SRC_W] == $past(ref_out_source_sel_q);
	endproperty
	a_read_src: assert property (p_read_src) else $error("source read wrong"); // R02

	// status bit 0 mirrors the same flop that feeds both consumers
	property p_read_status;
		@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && paddr == ADDR_STATUS) |=> prdata[0] == $past(ref_q);
	endproperty
	a_read_status: assert property (p_read_status) else $error("status level wrong"); // R01
endmodule

// ==== test/ref_src_model.sv ====
// Purpose: source clock model giving one tick per source edge
// Assumes: source i ticks every i+2 pclk cycles
// Notes: sources run free and never stop, as a clock kept alive in sleep would
`timescale 1ns/1ps
module ref_src_model #(
	parameter int NSRC = 4
)(
	input wire logic clk,
	input wire logic rst_n,
	output wire logic [NSRC-1:0] tick
);
	// one counter per source, local to its loop pass so each has one driver
	for (genvar i = 0; i < NSRC; i++) begin : g_src
		logic [3:0] cnt_q;
		logic tk_q;
		assign tick[i] = tk_q;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_q <= 4'h0;
				tk_q <= 1'b0;
			end else begin
				cnt_q <= (cnt_q == 4'(i + 1)) ? 4'h0 : cnt_q + 4'h1;
				tk_q <= (cnt_q == 4'(i + 1));
			end
		end
	end
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the reference clock output block
// Assumes: one wait state apb slave, ticks from the source model
// Notes: high time counted over two output periods after one settling period
`timescale 1ns/1ps
module tb_top;
	import ref_out_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, modc;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] src_tick;
	logic e;
	int num_errors, n_checks, cyc_cnt;
	typedef struct {logic [1:0] src; logic [2:0] div; logic [1:0] duty; int q;} row_type;
	row_type rows [8] = '{'{0, 0, 1, 2}, '{0, 1, 1, 1}, '{0, 2, 2, 2}, '{0, 3, 3, 3},
		'{3, 4, 0, 0}, '{1, 5, 3, 3}, '{2, 6, 1, 1}, '{0, 7, 2, 2}};
	ref_src_model #(.NSRC(4)) ref_src_model_inst (.clk(pclk), .rst_n(presetn), .tick(src_tick));
	ref_out_top #(.NSRC(4)) ref_out_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_tick(src_tick), .ref_clock_out_pin(pin),
		.modulator_ref_clk(modc));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle cycle: a following call must not drive psel twice in one step
		@(posedge pclk);
	endtask
	task automatic measure(input int per, input int exp);
		int hi, diff;
		hi = 0;
		diff = 0;
		repeat (per) @(posedge pclk);
		repeat (2 * per) begin
			@(posedge pclk);
			hi += (pin === 1'b1);
			diff += (pin !== modc);
		end
		check(32'(hi), 32'(exp));
		check(32'(diff), 32'h0);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc_cnt++;
		if (cyc_cnt == 30000) begin
			num_errors++;
			print_verdict;
		end
	end
	initial begin
		int per;
		{psel, penable, pwrite, paddr, pwdata, num_errors, n_checks, cyc_cnt} = '0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		check(r, 32'h10);
		apb(1'b0, 12'h00c, 32'h0);
		check({r[30:0], e}, 32'h1);
		check(32'(pin), 32'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			per = (2 << rows[i].div) * (rows[i].src + 2);
			apb(1'b1, ADDR_CONTROL, 32'h0);
			apb(1'b1, ADDR_SOURCE, 32'(rows[i].src));
			apb(1'b1, ADDR_CONTROL, {24'h0, 1'b1, 2'b00, rows[i].duty, rows[i].div});
			measure(per, 2 * per * rows[i].q / 4);
			$display("row %0d done", i);
		end
		apb(1'b1, ADDR_SOURCE, 32'h0);
		apb(1'b1, ADDR_CONTROL, 32'h8a);
		apb(1'b1, ADDR_CONTROL, 32'h8a);
		measure(16, 8);
		apb(1'b1, ADDR_CONTROL, 32'h9f);
		repeat (600) @(posedge pclk);
		check(32'(pin), 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h19);
		check(32'(pin), 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(r, 32'h0);
		$display("live change and stop test done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(32'(pin), 32'h0);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		check(r, 32'h10);
		$display("mid-run reset test done");
		print_verdict;
	end
endmodule
